// ===== hw/udi_engine.sv
// One device engine: enable, status, address, frame timeout and request logic
`timescale 1ns/1ns
module udi_engine #(
  parameter logic [15:0] EN_OFS = 16'hC08C,
  parameter logic [15:0] ADDR_OFS = 16'hC08E,
  parameter logic [15:0] STAT_OFS = 16'hC090,
  parameter logic [15:0] FRAME_OFS = 16'hC092,
  parameter logic [15:0] SOFCNT_OFS = 16'hC094,
  parameter logic [15:0] EN_MASK = 16'hCBFF,
  parameter logic [15:0] STAT_MASK = 16'hCBFF,
  parameter int EP_NUM = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  input wire logic vbus_edge,
  input wire logic id_edge,
  input wire logic sof_rx,
  input wire logic bus_rst,
  input wire logic tok_valid,
  input wire logic [6:0] tok_addr,
  input wire logic [EP_NUM-1:0] ep_ack,
  input wire logic [EP_NUM-1:0] ep_stall,
  input wire logic [EP_NUM-1:0] ep_tmo,
  input wire logic [EP_NUM-1:0] ep_in_exc,
  input wire logic [EP_NUM-1:0] ep_out_exc,
  input wire logic [EP_NUM-1:0] ep_nak,
  input wire logic [EP_NUM-1:0] ep_nak_ie,
  output logic irq,
  output logic tok_match,
  output logic [6:0] dev_addr
);
  logic [15:0] en_ff;
  logic [15:0] stat_ff;
  logic [6:0] addr_ff;
  logic [15:0] frame_ff;
  logic [15:0] sofcnt_ff;
  logic [15:0] tmr_ff;
  logic irq_ff;
  logic match_ff;
  wire wr_en_reg = wr_en && (addr == EN_OFS);
  wire wr_addr_reg = wr_en && (addr == ADDR_OFS);
  wire wr_stat_reg = wr_en && (addr == STAT_OFS);
  wire wr_sofcnt_reg = wr_en && (addr == SOFCNT_OFS);
  wire tmr_expire = (tmr_ff >= sofcnt_ff);
  wire [EP_NUM-1:0] ep_done = ep_ack | ep_stall | ep_tmo | ep_in_exc | ep_out_exc | (ep_nak & ep_nak_ie);
  logic [15:0] ev;
  always_comb begin
    ev = 16'h0000;
    ev[EP_NUM-1:0] = ep_done;
    ev[udi_pkg::UDI_RST_BIT] = bus_rst;
    ev[udi_pkg::UDI_SOF_BIT] = sof_rx;
    ev[udi_pkg::UDI_TMO_BIT] = tmr_expire;
    ev[udi_pkg::UDI_ID_BIT] = id_edge;
    ev[udi_pkg::UDI_VBUS_BIT] = vbus_edge;
  end
  // Only enabled sources latch; set wins over a one-to-clear in the same cycle
  wire [15:0] clr = wr_stat_reg ? wdata : 16'h0000;
  wire [15:0] nxt_stat = ((stat_ff & ~clr) | (ev & en_ff)) & STAT_MASK;
  wire [15:0] nxt_en = (wdata & EN_MASK);
  wire nxt_irq = |(stat_ff & en_ff);
  wire nxt_match = tok_valid && (tok_addr == addr_ff);
  wire [15:0] nxt_frame = sof_rx ? 16'h0000 : (tmr_expire ? frame_ff + 16'h0001 : frame_ff);
  wire [15:0] nxt_tmr = (sof_rx || tmr_expire) ? 16'h0000 : tmr_ff + 16'h0001;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_ff <= udi_pkg::UDI_EN_RST;
      stat_ff <= 16'h0000;
      addr_ff <= udi_pkg::UDI_ADDR_RST;
      frame_ff <= 16'h0000;
      sofcnt_ff <= udi_pkg::UDI_SOFCNT_RST;
      tmr_ff <= 16'h0000;
      irq_ff <= 1'b0;
      match_ff <= 1'b0;
    end else begin
      if (wr_en_reg) en_ff <= nxt_en;
      if (wr_addr_reg) addr_ff <= wdata[6:0];
      if (wr_sofcnt_reg) sofcnt_ff <= wdata;
      stat_ff <= nxt_stat;
      frame_ff <= nxt_frame;
      tmr_ff <= nxt_tmr;
      irq_ff <= nxt_irq;
      match_ff <= nxt_match;
    end
  end
  // Address register is write-only and reads back as zero
  always_comb begin
    if (addr == EN_OFS) rdata = en_ff;
    else if (addr == STAT_OFS) rdata = stat_ff;
    else if (addr == FRAME_OFS) rdata = frame_ff;
    else if (addr == SOFCNT_OFS) rdata = sofcnt_ff;
    else rdata = 16'h0000;
  end
  assign irq = irq_ff;
  assign tok_match = match_ff;
  assign dev_addr = addr_ff;
endmodule : udi_engine

// ===== hw/udi_pkg.sv
// Package of register offsets, field positions and reset values for the device interrupt enable block
// Overview of operation
// - Engine 1 flags bus-power threshold crossings both ways when bit 15 enabled.
// - Engine 1 flags every identification pin edge when bit 14 enabled.
// - Bits 15 and 14 exist only in engine 1; reserved in engine 2.
// - Bit 11 enables interrupt when no frame marker arrives within programmed count.
// - Frame register counts timeouts between consecutive received frame markers.
// - Bit 9 gates the frame marker received interrupt.
// - Bit 8 gates the bus reset detected interrupt.
// - Bits 0 to 7 gate the matching endpoint transaction-done interrupt.
// - Endpoint done fires on ack, stall, timeout, or direction exception.
// - With endpoint negative-acknowledge enable set, a negative acknowledge also fires done.
// - Implemented enable bits are read/write, active high, reset to zero.
// - Write-only address register holds 7-bit bus address in bits 6 to 0.
// - Device answers only traffic for its held address.
// - Writing one to a status bit clears that pending flag.
package udi_pkg;
  localparam logic [15:0] UDI_E1_IRQ_EN_OFS = 16'hC08C;
  localparam logic [15:0] UDI_E1_ADDR_OFS = 16'hC08E;
  localparam logic [15:0] UDI_E1_STAT_OFS = 16'hC090;
  localparam logic [15:0] UDI_E1_FRAME_OFS = 16'hC092;
  localparam logic [15:0] UDI_E1_SOFCNT_OFS = 16'hC094;
  localparam logic [15:0] UDI_E2_IRQ_EN_OFS = 16'hC0AC;
  localparam logic [15:0] UDI_E2_ADDR_OFS = 16'hC0AE;
  localparam logic [15:0] UDI_E2_STAT_OFS = 16'hC0B0;
  localparam logic [15:0] UDI_E2_FRAME_OFS = 16'hC0B2;
  localparam logic [15:0] UDI_E2_SOFCNT_OFS = 16'hC0B4;
  localparam int UDI_VBUS_BIT = 15;
  localparam int UDI_ID_BIT = 14;
  localparam int UDI_TMO_BIT = 11;
  localparam int UDI_SOF_BIT = 9;
  localparam int UDI_RST_BIT = 8;
  localparam int UDI_EP_NUM = 8;
  localparam logic [15:0] UDI_E1_EN_MASK = 16'hCBFF;
  localparam logic [15:0] UDI_E2_EN_MASK = 16'h0BFF;
  localparam logic [15:0] UDI_E1_STAT_MASK = 16'hCBFF;
  localparam logic [15:0] UDI_E2_STAT_MASK = 16'h0BFF;
  localparam logic [15:0] UDI_ADDR_MASK = 16'h007F;
  localparam logic [15:0] UDI_EN_RST = 16'h0000;
  localparam logic [6:0] UDI_ADDR_RST = 7'h00;
  localparam logic [15:0] UDI_SOFCNT_RST = 16'h2EE0;
endpackage : udi_pkg

// ===== hw/udi_top.sv
// Top of the two-engine device interrupt enable and address block
`timescale 1ns/1ns
module udi_top #(
  parameter int EP_NUM = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic vbus_valid_pin,
  input wire logic otg_id_pin,
  input wire logic [1:0] sof_rx,
  input wire logic [1:0] bus_rst,
  input wire logic [1:0] tok_valid,
  input wire logic [13:0] tok_addr,
  input wire logic [2*EP_NUM-1:0] ep_ack,
  input wire logic [2*EP_NUM-1:0] ep_stall,
  input wire logic [2*EP_NUM-1:0] ep_tmo,
  input wire logic [2*EP_NUM-1:0] ep_in_exc,
  input wire logic [2*EP_NUM-1:0] ep_out_exc,
  input wire logic [2*EP_NUM-1:0] ep_nak,
  input wire logic [2*EP_NUM-1:0] ep_nak_ie,
  output logic [1:0] irq,
  output logic [1:0] tok_match,
  output logic [13:0] dev_addr
);
  logic [2:0] vbus_sync_ff;
  logic [2:0] id_sync_ff;
  logic [15:0] rdata_ff;
  logic [15:0] rd1;
  logic [15:0] rd2;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vbus_sync_ff <= 3'h0;
      id_sync_ff <= 3'h0;
      rdata_ff <= 16'h0000;
    end else begin
      vbus_sync_ff <= {vbus_sync_ff[1:0], vbus_valid_pin};
      id_sync_ff <= {id_sync_ff[1:0], otg_id_pin};
      rdata_ff <= rd1 | rd2;
    end
  end
  wire vbus_edge = vbus_sync_ff[2] ^ vbus_sync_ff[1];
  wire id_edge = id_sync_ff[2] ^ id_sync_ff[1];
  udi_engine #(
    .EN_OFS(udi_pkg::UDI_E1_IRQ_EN_OFS), .ADDR_OFS(udi_pkg::UDI_E1_ADDR_OFS),
    .STAT_OFS(udi_pkg::UDI_E1_STAT_OFS), .FRAME_OFS(udi_pkg::UDI_E1_FRAME_OFS),
    .SOFCNT_OFS(udi_pkg::UDI_E1_SOFCNT_OFS), .EN_MASK(udi_pkg::UDI_E1_EN_MASK),
    .STAT_MASK(udi_pkg::UDI_E1_STAT_MASK), .EP_NUM(EP_NUM)
  ) u_eng1 (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(reg_wr), .addr(reg_addr), .wdata(reg_wdata),
    .rdata(rd1), .vbus_edge(vbus_edge), .id_edge(id_edge), .sof_rx(sof_rx[0]), .bus_rst(bus_rst[0]),
    .tok_valid(tok_valid[0]), .tok_addr(tok_addr[6:0]), .ep_ack(ep_ack[EP_NUM-1:0]),
    .ep_stall(ep_stall[EP_NUM-1:0]), .ep_tmo(ep_tmo[EP_NUM-1:0]), .ep_in_exc(ep_in_exc[EP_NUM-1:0]),
    .ep_out_exc(ep_out_exc[EP_NUM-1:0]), .ep_nak(ep_nak[EP_NUM-1:0]), .ep_nak_ie(ep_nak_ie[EP_NUM-1:0]),
    .irq(irq[0]), .tok_match(tok_match[0]), .dev_addr(dev_addr[6:0])
  );
  // Second engine sees no bus-power or identification events
  udi_engine #(
    .EN_OFS(udi_pkg::UDI_E2_IRQ_EN_OFS), .ADDR_OFS(udi_pkg::UDI_E2_ADDR_OFS),
    .STAT_OFS(udi_pkg::UDI_E2_STAT_OFS), .FRAME_OFS(udi_pkg::UDI_E2_FRAME_OFS),
    .SOFCNT_OFS(udi_pkg::UDI_E2_SOFCNT_OFS), .EN_MASK(udi_pkg::UDI_E2_EN_MASK),
    .STAT_MASK(udi_pkg::UDI_E2_STAT_MASK), .EP_NUM(EP_NUM)
  ) u_eng2 (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wr_en(reg_wr), .addr(reg_addr), .wdata(reg_wdata),
    .rdata(rd2), .vbus_edge(1'b0), .id_edge(1'b0), .sof_rx(sof_rx[1]), .bus_rst(bus_rst[1]),
    .tok_valid(tok_valid[1]), .tok_addr(tok_addr[13:7]), .ep_ack(ep_ack[2*EP_NUM-1:EP_NUM]),
    .ep_stall(ep_stall[2*EP_NUM-1:EP_NUM]), .ep_tmo(ep_tmo[2*EP_NUM-1:EP_NUM]),
    .ep_in_exc(ep_in_exc[2*EP_NUM-1:EP_NUM]), .ep_out_exc(ep_out_exc[2*EP_NUM-1:EP_NUM]),
    .ep_nak(ep_nak[2*EP_NUM-1:EP_NUM]), .ep_nak_ie(ep_nak_ie[2*EP_NUM-1:EP_NUM]),
    .irq(irq[1]), .tok_match(tok_match[1]), .dev_addr(dev_addr[13:7])
  );
  assign reg_rdata = rdata_ff;
endmodule : udi_top

// ===== testbench/udi_sva.sv
// Port checker of the device interrupt enable and address block
`timescale 1ns/1ns
module udi_sva (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0] tok_valid,
  input wire logic [13:0] tok_addr,
  input wire logic [1:0] irq,
  input wire logic [1:0] tok_match,
  input wire logic [13:0] dev_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire en_a = reg_addr == udi_pkg::UDI_E1_IRQ_EN_OFS;
  wire ad_a = reg_addr == udi_pkg::UDI_E1_ADDR_OFS;
  wire hit = tok_valid[0] && tok_addr[6:0] == dev_addr[6:0];
  chk_rst_clear: assert property ($fell(sys_rst) |-> !irq && !dev_addr)
    else $error("outputs not cleared");
  chk_tok_hit: assert property (hit |=> tok_match[0])
    else $error("token missed");
  chk_tok_miss: assert property (!hit |=> !tok_match[0])
    else $error("stray match");
  chk_addr_load: assert property (reg_wr && ad_a |=> dev_addr[6:0] == $past(reg_wdata[6:0]))
    else $error("address not loaded");
  chk_addr_hold: assert property (!(reg_wr && ad_a) |=> $stable(dev_addr[6:0]))
    else $error("address moved");
  chk_addr_wo: assert property (ad_a |=> !reg_rdata)
    else $error("address readable");
  chk_en_back: assert property ((reg_wr && en_a) ##1 (!reg_wr && en_a) |=>
    reg_rdata == ($past(reg_wdata, 2) & udi_pkg::UDI_E1_EN_MASK)) else $error("enable readback");
  chk_irq_off: assert property (reg_wr && en_a && !reg_wdata |=> ##1 !irq[0])
    else $error("irq while disabled");
  cover property (hit);
  cover property ((reg_wr && en_a) ##1 (!reg_wr && en_a));
  cover property (irq[0] ##1 !irq[0]);
endmodule : udi_sva
bind udi_top udi_sva i_udi_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_addr(tok_addr), .irq(irq),
  .tok_match(tok_match), .dev_addr(dev_addr));

// ===== testbench/udi_host_model.sv
// Host model: frame markers, bus resets and addressed tokens
`timescale 1ns/1ns
module udi_host_model (
  input wire logic sys_clk,
  output logic [1:0] sof_rx = 2'b00,
  output logic [1:0] bus_rst = 2'b00,
  output logic [1:0] tok_valid = 2'b00,
  output logic [13:0] tok_addr = 14'h0000
);
  // Kind 0 marker, 1 bus reset, 2 token; silence lets the device time out
  task automatic send(input int kind, eng, input logic [6:0] a);
    @(negedge sys_clk);
    sof_rx[eng] = kind == 0;
    bus_rst[eng] = kind == 1;
    tok_valid[eng] = kind == 2;
    tok_addr[eng*7 +: 7] = a;
    @(negedge sys_clk);
    {sof_rx, bus_rst, tok_valid} = 6'h00;
    tok_addr = ~tok_addr;
  endtask : send
endmodule : udi_host_model

// ===== testbench/udi_top_bench.sv
// Self-checking bench of the device interrupt enable block
`timescale 1ns/1ns
module udi_top_bench;
  localparam logic [15:0] EN1 = udi_pkg::UDI_E1_IRQ_EN_OFS;
  localparam logic [15:0] ST1 = udi_pkg::UDI_E1_STAT_OFS;
  localparam logic [15:0] CLR = udi_pkg::UDI_E1_STAT_MASK;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, vbus = 1'b0, otg_id = 1'b0, obs = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, r, q[$];
  logic [15:0] ev[7] = '{default: 16'h0000};
  wire [15:0] rdata;
  wire [1:0] sof, brst, tv, irq, tm;
  wire [13:0] ta, da;
  int n_mismatch = 0, checks = 0, seed = 32'h21807726, e;
  initial forever #25 sys_clk = ~sys_clk;
  udi_host_model i_udi_host_model (.sys_clk(sys_clk), .sof_rx(sof), .bus_rst(brst), .tok_valid(tv), .tok_addr(ta));
  udi_top i_udi_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .vbus_valid_pin(vbus), .otg_id_pin(otg_id), .sof_rx(sof),
    .bus_rst(brst), .tok_valid(tv), .tok_addr(ta), .ep_ack(ev[0]), .ep_stall(ev[1]), .ep_tmo(ev[2]),
    .ep_in_exc(ev[3]), .ep_out_exc(ev[4]), .ep_nak(ev[5]), .ep_nak_ie(ev[6]), .irq(irq), .tok_match(tm),
    .dev_addr(da));
  task automatic check(input string n, input logic [15:0] s, x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", n, x, s);
    end
  endtask : check
  // Write when w is set, else read with d as the expected data
  task automatic acc(input bit w, input logic [15:0] a, d);
    @(negedge sys_clk);
    {reg_wr, obs, reg_addr, reg_wdata} = {w, !w, a, d};
    if (!w) q.push_back(d);
    @(negedge sys_clk);
    {reg_wr, obs} = 2'b00;
  endtask : acc
  always @(posedge sys_clk) begin
    #1;
    if (obs) check("rdata", rdata, q.pop_front());
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #1000000 n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    acc(0, EN1, udi_pkg::UDI_EN_RST);
    acc(0, 16'hC0FE, 16'h0000);
    r = $random(seed);
    acc(1, EN1, r & udi_pkg::UDI_E1_EN_MASK);
    acc(1, udi_pkg::UDI_E2_IRQ_EN_OFS, r & udi_pkg::UDI_E2_EN_MASK);
    acc(0, EN1, r & udi_pkg::UDI_E1_EN_MASK);
    acc(0, udi_pkg::UDI_E2_IRQ_EN_OFS, r & udi_pkg::UDI_E2_EN_MASK);
    acc(1, udi_pkg::UDI_E1_ADDR_OFS, r & udi_pkg::UDI_ADDR_MASK);
    check("dev_addr", {2'b00, da}, {9'h000, r[6:0]});
    for (int k = 0; k < 3; k++) begin
      i_udi_host_model.send(2, k / 2, k == 0 ? r[6:0] : k == 1 ? ~r[6:0] : 7'h00);
      check("tok_match", {14'h0000, tm}, {14'h0000, k == 2, k == 0});
    end
    $display("registers and tokens done");
    for (int k = 0; k < 7; k++) begin
      e = $unsigned($random(seed)) % 8;
      ev[6] = (k == 5) ? 16'h00FF : 16'h0000;
      acc(1, EN1, 16'h0001 << e);
      @(negedge sys_clk);
      ev[k == 6 ? 5 : k][e] = 1'b1;
      @(negedge sys_clk);
      ev[k == 6 ? 5 : k] = 16'h0000;
      repeat (2) @(negedge sys_clk);
      check("irq", {14'h0000, irq}, {15'h0000, k != 6});
      acc(0, ST1, (k != 6) ? 16'h0001 << e : 16'h0000);
      acc(1, ST1, CLR);
      @(negedge sys_clk);
      check("irq", {14'h0000, irq}, 16'h0000);
    end
    $display("endpoint events done");
    acc(1, udi_pkg::UDI_E1_SOFCNT_OFS, 16'h0010);
    acc(1, EN1, 16'h0A00);
    i_udi_host_model.send(0, 0, 7'h00);
    @(negedge sys_clk);
    check("irq", {14'h0000, irq}, 16'h0001);
    acc(1, ST1, CLR);
    acc(0, udi_pkg::UDI_E1_FRAME_OFS, 16'h0000);
    repeat (36) @(negedge sys_clk);
    check("irq", {14'h0000, irq}, 16'h0001);
    acc(0, udi_pkg::UDI_E1_FRAME_OFS, 16'h0002);
    acc(0, ST1, 16'h0800);
    $display("frame timeout done");
    acc(1, EN1, 16'hC100);
    acc(1, ST1, CLR);
    for (int k = 0; k < 5; k++) begin
      if (k < 2) vbus = (k == 0);
      else if (k < 4) otg_id = (k == 2);
      else i_udi_host_model.send(1, 0, 7'h00);
      repeat (6) @(negedge sys_clk);
      check("irq", {14'h0000, irq}, 16'h0001);
      acc(0, ST1, k < 2 ? 16'h8000 : k < 4 ? 16'h4000 : 16'h0100);
      acc(1, ST1, CLR);
    end
    // Leave a flag pending, then disabling the source must drop the request
    vbus = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("irq", {14'h0000, irq}, 16'h0001);
    acc(1, EN1, 16'h0000);
    repeat (2) @(negedge sys_clk);
    check("irq", {14'h0000, irq}, 16'h0000);
    $display("pin edges done");
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    check("dev_addr", {2'b00, da}, 16'h0000);
    acc(0, EN1, udi_pkg::UDI_EN_RST);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule : udi_top_bench
